// *** rtl/lcg1_pkg.sv ***
package lcg1_pkg;
  // Register map, byte addresses on the 32-bit register bus
  localparam int          ADDR_W           = 8;
  localparam logic [7:0]  CHAN_SEL_LO_OFS  = 8'h00;
  localparam logic [7:0]  CHAN_SEL_HI_OFS  = 8'h04;
  localparam logic [7:0]  GATE_ONE_SEL_OFS = 8'h08;
  localparam logic [7:0]  CELL_STATUS_OFS  = 8'h0C;

  // Channel source selection
  localparam int          NUM_SRC          = 16;
  localparam int          NUM_CHAN         = 4;
  localparam int          SEL_W            = 4;
  localparam int          CHAN_A_LSB       = 0;
  localparam int          CHAN_B_LSB       = 4;

  // Gate one select bits
  localparam int          GATE_ONE_CHAN_ONE_INV_SEL_BIT    = 0;
  localparam int          GATE_ONE_CHAN_ONE_TRUE_SEL_BIT   = 1;
  localparam int          GATE_ONE_CHAN_TWO_INV_SEL_BIT    = 2;
  localparam int          GATE_ONE_CHAN_TWO_TRUE_SEL_BIT   = 3;
  localparam int          GATE_ONE_CHAN_THREE_INV_SEL_BIT  = 4;
  localparam int          GATE_ONE_CHAN_THREE_TRUE_SEL_BIT = 5;
  localparam int          GATE_ONE_CHAN_FOUR_INV_SEL_BIT   = 6;
  localparam int          GATE_ONE_CHAN_FOUR_TRUE_SEL_BIT  = 7;

  // Status layout
  localparam int          STAT_GATE_BIT    = 0;
  localparam int          STAT_CHAN_LSB    = 4;

  // Reset values
  localparam logic [7:0]  CHAN_SEL_RST     = 8'h00;
  localparam logic [7:0]  GATE_ONE_SEL_RST = 8'h00;
  localparam logic [31:0] RDATA_ZERO       = 32'h0000_0000;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage : lcg1_pkg

// *** rtl/lcg1_sync.sv ***
`timescale 1ns/1ps
module lcg1_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : lcg1_sync

// *** rtl/lcg1_chan_mux.sv ***
`timescale 1ns/1ps
module lcg1_chan_mux #(
  parameter int NUM_SRC = 16,
  parameter int SEL_W   = 4
) (
  input  wire logic [NUM_SRC-1:0] src,
  input  wire logic [SEL_W-1:0]   sel,
  output logic                    chan
);
  // One of the cell sources becomes this data channel
  assign chan = src[sel];
endmodule : lcg1_chan_mux

// *** rtl/lcg1_top.sv ***
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module lcg1_top
  import lcg1_pkg::*;
#(
  parameter int NUM_SRC_P = lcg1_pkg::NUM_SRC
) (
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic [NUM_SRC_P-1:0] cell_in,
  input  wire logic [31:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [31:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic                      gate_one_signal
);
  import lcg1_pkg::*;

  logic [NUM_SRC_P-1:0]    cell_sync;
  logic [NUM_CHAN-1:0]     chan_vec;
  logic [2*NUM_CHAN-1:0]   gate_terms;
  logic [2*SEL_W-1:0]      sel_field [NUM_CHAN/2];

  logic [7:0]              chan_sel_lo_ff;
  logic [7:0]              chan_sel_hi_ff;
  logic [7:0]              gate_one_data_select_ff;
  logic                    gate_one_signal_ff;
  logic [7:0]              nxt_chan_sel_lo;
  logic [7:0]              nxt_chan_sel_hi;
  logic [7:0]              nxt_gate_one_data_select;
  logic                    nxt_gate_one_signal;

  logic                    aw_full_ff;
  logic [ADDR_W-1:0]       awaddr_ff;
  logic                    w_full_ff;
  logic [7:0]              wdata_ff;
  logic                    wstrb0_ff;
  logic                    awready_ff;
  logic                    wready_ff;
  logic                    bvalid_ff;
  logic [1:0]              bresp_ff;
  logic                    arready_ff;
  logic                    rvalid_ff;
  logic [31:0]             rdata_ff;
  logic [1:0]              rresp_ff;
  logic                    nxt_aw_full;
  logic [ADDR_W-1:0]       nxt_awaddr;
  logic                    nxt_w_full;
  logic [7:0]              nxt_wdata;
  logic                    nxt_wstrb0;
  logic                    nxt_awready;
  logic                    nxt_wready;
  logic                    nxt_bvalid;
  logic [1:0]              nxt_bresp;
  logic                    nxt_arready;
  logic                    nxt_rvalid;
  logic [31:0]             nxt_rdata;
  logic [1:0]              nxt_rresp;

  // Cell sources may come straight from pins
  lcg1_sync #(
    .WIDTH    (NUM_SRC_P)
  ) u_sync (
    .mclk     (mclk),
    .reset    (reset),
    .async_in (cell_in),
    .sync_out (cell_sync)
  );

  assign sel_field[0] = chan_sel_lo_ff;
  assign sel_field[1] = chan_sel_hi_ff;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
      // Even channels use the low nibble of their select register
      lcg1_chan_mux #(
        .NUM_SRC (NUM_SRC_P),
        .SEL_W   (SEL_W)
      ) u_mux (
        .src     (cell_sync),
        .sel     (sel_field[gi/2][(gi%2)*SEL_W +: SEL_W]),
        .chan    (chan_vec[gi])
      );
      // Odd select bit gates the true form, even bit the complement
      assign gate_terms[2*gi+1] = chan_vec[gi] & gate_one_data_select_ff[2*gi+1];
      assign gate_terms[2*gi]   = ~chan_vec[gi] & gate_one_data_select_ff[2*gi];
    end
  endgenerate

  always_comb begin
    nxt_gate_one_signal = |gate_terms;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      gate_one_signal_ff <= 1'b0;
    end else begin
      gate_one_signal_ff <= nxt_gate_one_signal;
    end
  end

  // Write path: address and data are captured independently, committed together
  always_comb begin
    nxt_aw_full              = aw_full_ff;
    nxt_awaddr               = awaddr_ff;
    nxt_w_full               = w_full_ff;
    nxt_wdata                = wdata_ff;
    nxt_wstrb0               = wstrb0_ff;
    nxt_bvalid               = bvalid_ff;
    nxt_bresp                = bresp_ff;
    nxt_chan_sel_lo          = chan_sel_lo_ff;
    nxt_chan_sel_hi          = chan_sel_hi_ff;
    nxt_gate_one_data_select = gate_one_data_select_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_full = 1'b1;
      nxt_awaddr  = s_axi_awaddr[ADDR_W-1:0];
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_full = 1'b1;
      nxt_wdata  = s_axi_wdata[7:0];
      nxt_wstrb0 = s_axi_wstrb[0];
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (aw_full_ff && w_full_ff && !bvalid_ff) begin
      nxt_aw_full = 1'b0;
      nxt_w_full  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = RESP_OKAY;
      // All fields live in byte lane 0, so only that strobe matters
      unique case (awaddr_ff)
        CHAN_SEL_LO_OFS: begin
          if (wstrb0_ff) nxt_chan_sel_lo = wdata_ff;
        end
        CHAN_SEL_HI_OFS: begin
          if (wstrb0_ff) nxt_chan_sel_hi = wdata_ff;
        end
        GATE_ONE_SEL_OFS: begin
          if (wstrb0_ff) nxt_gate_one_data_select = wdata_ff;
        end
        CELL_STATUS_OFS: begin
          nxt_bresp = RESP_OKAY;
        end
        default: begin
          nxt_bresp = RESP_SLVERR;
        end
      endcase
    end
    // Hold off new requests while a response is outstanding
    nxt_awready = !nxt_aw_full && !nxt_bvalid;
    nxt_wready  = !nxt_w_full && !nxt_bvalid;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      aw_full_ff              <= 1'b0;
      awaddr_ff               <= '0;
      w_full_ff               <= 1'b0;
      wdata_ff                <= 8'h00;
      wstrb0_ff               <= 1'b0;
      awready_ff              <= 1'b0;
      wready_ff               <= 1'b0;
      bvalid_ff               <= 1'b0;
      bresp_ff                <= RESP_OKAY;
      chan_sel_lo_ff          <= CHAN_SEL_RST;
      chan_sel_hi_ff          <= CHAN_SEL_RST;
      gate_one_data_select_ff <= GATE_ONE_SEL_RST;
    end else begin
      aw_full_ff              <= nxt_aw_full;
      awaddr_ff               <= nxt_awaddr;
      w_full_ff               <= nxt_w_full;
      wdata_ff                <= nxt_wdata;
      wstrb0_ff               <= nxt_wstrb0;
      awready_ff              <= nxt_awready;
      wready_ff               <= nxt_wready;
      bvalid_ff               <= nxt_bvalid;
      bresp_ff                <= nxt_bresp;
      chan_sel_lo_ff          <= nxt_chan_sel_lo;
      chan_sel_hi_ff          <= nxt_chan_sel_hi;
      gate_one_data_select_ff <= nxt_gate_one_data_select;
    end
  end

  // Read path: one outstanding read, data answered one edge after address
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = RDATA_ZERO;
      nxt_rresp  = RESP_OKAY;
      unique case (s_axi_araddr[ADDR_W-1:0])
        CHAN_SEL_LO_OFS:  nxt_rdata[7:0] = chan_sel_lo_ff;
        CHAN_SEL_HI_OFS:  nxt_rdata[7:0] = chan_sel_hi_ff;
        GATE_ONE_SEL_OFS: nxt_rdata[7:0] = gate_one_data_select_ff;
        CELL_STATUS_OFS: begin
          nxt_rdata[STAT_GATE_BIT]                   = gate_one_signal_ff;
          nxt_rdata[STAT_CHAN_LSB +: NUM_CHAN]       = chan_vec;
        end
        default: nxt_rresp = RESP_SLVERR;
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= RDATA_ZERO;
      rresp_ff   <= RESP_OKAY;
    end else begin
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  assign s_axi_awready   = awready_ff;
  assign s_axi_wready    = wready_ff;
  assign s_axi_bvalid    = bvalid_ff;
  assign s_axi_bresp     = bresp_ff;
  assign s_axi_arready   = arready_ff;
  assign s_axi_rvalid    = rvalid_ff;
  assign s_axi_rdata     = rdata_ff;
  assign s_axi_rresp     = rresp_ff;
  assign gate_one_signal = gate_one_signal_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_chan_four_true;
    gate_one_data_select_ff[GATE_ONE_CHAN_FOUR_TRUE_SEL_BIT] && chan_vec[3]
      |=> gate_one_signal_ff;
  endproperty
  a_chan_four_true: assert property (p_chan_four_true)
    else $error("Channel four true not gated in");

  property p_chan_four_inv;
    gate_one_data_select_ff[GATE_ONE_CHAN_FOUR_INV_SEL_BIT] && !chan_vec[3]
      |=> gate_one_signal_ff;
  endproperty
  a_chan_four_inv: assert property (p_chan_four_inv)
    else $error("Channel four complement not gated in");

  property p_chan_three_true;
    gate_one_data_select_ff[GATE_ONE_CHAN_THREE_TRUE_SEL_BIT] && chan_vec[2]
      |=> gate_one_signal_ff;
  endproperty
  a_chan_three_true: assert property (p_chan_three_true)
    else $error("Channel three true not gated in");

  property p_chan_three_inv;
    gate_one_data_select_ff[GATE_ONE_CHAN_THREE_INV_SEL_BIT] && !chan_vec[2]
      |=> gate_one_signal_ff;
  endproperty
  a_chan_three_inv: assert property (p_chan_three_inv)
    else $error("Channel three complement not gated in");

  property p_chan_two_true;
    gate_one_data_select_ff[GATE_ONE_CHAN_TWO_TRUE_SEL_BIT] && chan_vec[1]
      |=> gate_one_signal_ff;
  endproperty
  a_chan_two_true: assert property (p_chan_two_true)
    else $error("Channel two true not gated in");

  property p_chan_two_inv;
    gate_one_data_select_ff[GATE_ONE_CHAN_TWO_INV_SEL_BIT] && !chan_vec[1]
      |=> gate_one_signal_ff;
  endproperty
  a_chan_two_inv: assert property (p_chan_two_inv)
    else $error("Channel two complement not gated in");

  // Only channel one true selected: gate follows channel one, one cycle later
  property p_chan_one_true;
    gate_one_data_select_ff == (8'h01 << GATE_ONE_CHAN_ONE_TRUE_SEL_BIT)
      |=> gate_one_signal_ff == $past(chan_vec[0]);
  endproperty
  a_chan_one_true: assert property (p_chan_one_true)
    else $error("Gate does not follow channel one true");

  property p_chan_one_inv;
    gate_one_data_select_ff == (8'h01 << GATE_ONE_CHAN_ONE_INV_SEL_BIT)
      |=> gate_one_signal_ff == !$past(chan_vec[0]);
  endproperty
  a_chan_one_inv: assert property (p_chan_one_inv)
    else $error("Gate does not follow channel one complement");

  property p_none_selected;
    gate_one_data_select_ff == GATE_ONE_SEL_RST |=> !gate_one_signal_ff;
  endproperty
  a_none_selected: assert property (p_none_selected)
    else $error("Gate high with nothing selected");

  sequence s_read_taken;
    s_axi_arvalid && arready_ff;
  endsequence

  property p_read_upper_zero;
    s_read_taken |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_read_upper_zero: assert property (p_read_upper_zero)
    else $error("Unimplemented read bits not zero");

  property p_status_unused_zero;
    s_read_taken ##0 (s_axi_araddr[ADDR_W-1:0] == CELL_STATUS_OFS)
      |=> s_axi_rdata[STAT_CHAN_LSB-1:STAT_GATE_BIT+1] == 3'h0;
  endproperty
  a_status_unused_zero: assert property (p_status_unused_zero)
    else $error("Status gap bits not zero");

  property p_chan_route;
    chan_vec[0] == cell_sync[chan_sel_lo_ff[CHAN_A_LSB +: SEL_W]]
      && chan_vec[3] == cell_sync[chan_sel_hi_ff[CHAN_B_LSB +: SEL_W]];
  endproperty
  a_chan_route: assert property (p_chan_route)
    else $error("Channel does not carry its selected source");

  sequence s_sel_commit;
    aw_full_ff && w_full_ff && !bvalid_ff && wstrb0_ff
      && awaddr_ff == GATE_ONE_SEL_OFS;
  endsequence

  property p_sel_commit;
    s_sel_commit |=> gate_one_data_select_ff == $past(wdata_ff) && s_axi_bvalid;
  endproperty
  a_sel_commit: assert property (p_sel_commit)
    else $error("Gate select write not applied");
endmodule : lcg1_top

// *** dv/test_logic_cell_gate1_data_select.sv ***
`timescale 1ns/1ps
module test_logic_cell_gate1_data_select;
  import lcg1_pkg::*;
  logic        mclk;
  logic        reset;
  logic [15:0] cell_in;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, gate;
  logic [1:0]  bresp, rresp;
  int          bad_count;
  int          n_checks;
  // Channel sources one..four; four sits on the top source index
  int          src_of [4] = '{3, 7, 11, 15};

  lcg1_top u_dut (
    .mclk(mclk), .reset(reset), .cell_in(cell_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .gate_one_signal(gate)
  );

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Handshakes are judged at the rising edge; the slave's flops have not moved yet
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    awaddr  <= {24'h00_0000, a};
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    araddr  <= {24'h00_0000, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d    = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_read

  task automatic test_reset_values();
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(GATE_ONE_SEL_OFS, d, r);
    check(d, 32'h0000_0000);
    axi_read(CHAN_SEL_LO_OFS, d, r);
    check(d, 32'h0000_0000);
  endtask : test_reset_values

  task automatic test_readback();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(CHAN_SEL_LO_OFS, 32'hA5A5_FF73, 4'hF, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    axi_write(CHAN_SEL_HI_OFS, 32'h5A5A_00FB, 4'hF, r);
    axi_read(CHAN_SEL_LO_OFS, d, r);
    check(d, 32'h0000_0073);
    axi_read(CHAN_SEL_HI_OFS, d, r);
    check(d, 32'h0000_00FB);
    axi_write(GATE_ONE_SEL_OFS, 32'hFFFF_FF00, 4'hF, r);
    axi_read(GATE_ONE_SEL_OFS, d, r);
    check(d, 32'h0000_0000);
  endtask : test_readback

  // Each select bit alone, target source at both levels, other sources opposite
  task automatic test_gating();
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] pat;
    logic        lv, exp_g;
    logic [3:0]  ch;
    for (int i = 0; i < 8; i++) begin
      axi_write(GATE_ONE_SEL_OFS, 32'h0000_0001 << i, 4'h1, r);
      for (int l = 0; l < 2; l++) begin
        lv  = l[0];
        pat = 16'h0001 << src_of[i / 2];
        if (!lv) pat = ~pat;
        @(posedge mclk);
        cell_in <= pat;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        exp_g = (i % 2 == 0) ? ~lv : lv;
        check({31'h0, gate}, {31'h0, exp_g});
        for (int c = 0; c < 4; c++) ch[c] = pat[src_of[c]];
        axi_read(CELL_STATUS_OFS, d, r);
        check(d, {24'h00_0000, ch, 3'h0, exp_g});
      end
    end
  endtask : test_gating

  task automatic test_strobe_and_both_terms();
    logic [31:0] d;
    logic [1:0]  r;
    // Lane zero off: the write must leave the select untouched
    axi_write(GATE_ONE_SEL_OFS, 32'h0000_00C0, 4'hE, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    axi_read(GATE_ONE_SEL_OFS, d, r);
    check(d, 32'h0000_0080);
    axi_write(GATE_ONE_SEL_OFS, 32'h0000_00C0, 4'h1, r);
    @(posedge mclk);
    cell_in <= 16'h0000;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    check({31'h0, gate}, 32'h0000_0001);
    axi_write(GATE_ONE_SEL_OFS, 32'h0000_0000, 4'h1, r);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check({31'h0, gate}, 32'h0000_0000);
  endtask : test_strobe_and_both_terms

  task automatic test_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(8'h10, 32'hFFFF_FFFF, 4'hF, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    // Status is read-only: a write is accepted and has no effect
    axi_write(CELL_STATUS_OFS, 32'hFFFF_FFFF, 4'hF, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    axi_read(8'h10, d, r);
    check(d, 32'h0000_0000);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask : test_unmapped

  // Reset in mid-run must drop the gate and clear the select
  task automatic test_mid_reset();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(GATE_ONE_SEL_OFS, 32'h0000_0055, 4'h1, r);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check({31'h0, gate}, 32'h0000_0001);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check({31'h0, gate}, 32'h0000_0000);
    axi_read(GATE_ONE_SEL_OFS, d, r);
    check(d, 32'h0000_0000);
  endtask : test_mid_reset

  initial begin
    bad_count = 0;
    n_checks  = 0;
    reset     = 1'b1;
    cell_in   = 16'h0000;
    awaddr    = 32'h0000_0000;
    wdata     = 32'h0000_0000;
    wstrb     = 4'h0;
    araddr    = 32'h0000_0000;
    awvalid   = 1'b0;
    wvalid    = 1'b0;
    bready    = 1'b0;
    arvalid   = 1'b0;
    rready    = 1'b0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    test_reset_values();
    test_readback();
    test_gating();
    test_strobe_and_both_terms();
    test_unmapped();
    test_mid_reset();
    final_report();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    final_report();
  end
endmodule : test_logic_cell_gate1_data_select
